// >>> hw/fifo_ctl_pkg.sv
// constants and types for the uart fifo control block
package fifo_ctl_pkg;

   localparam logic [15:0] UART0_FIFO_CONTROL_ADDR = 16'h00c2;
   localparam logic [15:0] UART1_FIFO_CONTROL_ADDR = 16'h00d2;
   localparam logic [7:0]  FIFO_CONTROL_RESET      = 8'h00;

   localparam int TRIGGER_LSB    = 6;
   localparam int TX_EN_BIT      = 2;
   localparam int RX_EN_BIT      = 1;
   localparam int FIFO_EN_BIT    = 0;
   localparam int IIR_FIFO_BIT   = 7;
   localparam int IIR_STATUS_W   = 4;

   localparam logic [1:0] TRIGGER_CODE_1  = 2'h0;
   localparam logic [1:0] TRIGGER_CODE_4  = 2'h1;
   localparam logic [1:0] TRIGGER_CODE_8  = 2'h2;
   localparam logic [1:0] TRIGGER_CODE_14 = 2'h3;

   localparam int LEVEL_W = 5;
   localparam logic [4:0] TRIGGER_LEVEL_1  = 5'h01;
   localparam logic [4:0] TRIGGER_LEVEL_4  = 5'h04;
   localparam logic [4:0] TRIGGER_LEVEL_8  = 5'h08;
   localparam logic [4:0] TRIGGER_LEVEL_14 = 5'h0e;

   localparam int DATA_W     = 8;
   localparam int FIFO_DEPTH = 16;

   typedef struct packed {
      logic [1:0] rx_trigger_level;
      logic       tx_path_enable;
      logic       rx_path_enable;
      logic       fifo_enable;
   } fifo_control_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } io_req_t;

   // hold flags kept as flops so the hold outputs need no inverter
   typedef struct packed {
      fifo_control_t ctl;
      logic [7:0]    rdata;
      logic          rx_irq;
      logic          rx_hold;
      logic          tx_hold;
   } ctl_state_t;

   localparam ctl_state_t CTL_STATE_RESET = '{
      ctl:     '0,
      rdata:   8'h00,
      rx_irq:  1'b0,
      rx_hold: 1'b1,
      tx_hold: 1'b1
   };

endpackage

// >>> hw/byte_fifo.sv
// circular fifo with registered flags and an optional one-entry limit
`timescale 1ns/1ns
`default_nettype none
module byte_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   input  wire logic                         clk_sys,
   input  wire logic                         rst,
   input  wire logic                         clear,
   input  wire logic                         single,
   input  wire logic                         in_valid,
   input  wire logic [WIDTH-1:0]             in_data,
   output logic                              in_ready,
   output logic                              out_valid,
   output logic [WIDTH-1:0]                  out_data,
   input  wire logic                         out_ready,
   output logic [$clog2(DEPTH+1)-1:0]        level
);
   // depth must be a power of two: pointers wrap by overflow
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   typedef struct packed {
      logic [AW-1:0]    head;
      logic [AW-1:0]    tail;
      logic [CW-1:0]    count;
      logic             in_ready;
      logic             out_valid;
      logic [WIDTH-1:0] out_data;
   } fifo_state_t;

   fifo_state_t      s_r;
   fifo_state_t      s_nxt;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push;
   logic             pop;
   logic [CW-1:0]    limit;
   logic [CW-1:0]    left;

   assign push  = in_valid & s_r.in_ready;
   assign pop   = out_ready & s_r.out_valid;
   assign limit = single ? CW'(1) : CW'(DEPTH);
   assign left  = s_r.count - CW'(pop);

   always_comb
   begin
      s_nxt = s_r;
      if (clear)
      begin
         s_nxt = '0;
      end
      else
      begin
         if (push)
            s_nxt.tail = AW'(s_r.tail + 1'b1);
         if (pop)
            s_nxt.head = AW'(s_r.head + 1'b1);
         s_nxt.count     = left + CW'(push);
         s_nxt.in_ready  = s_nxt.count < limit;
         s_nxt.out_valid = s_nxt.count != '0;
         // show-ahead: a byte into an emptying fifo bypasses the array
         if (push && left == '0)
            s_nxt.out_data = in_data;
         else
            s_nxt.out_data = mem[s_nxt.head];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   always_ff @(posedge clk_sys)
   begin
      if (push)
         mem[s_r.tail] <= in_data;
   end

   assign in_ready  = s_r.in_ready;
   assign out_valid = s_r.out_valid;
   assign out_data  = s_r.out_data;
   assign level     = s_r.count;

endmodule // byte_fifo
`default_nettype wire

// >>> hw/uart_fifo_control.sv
// fifo control register and fifo data paths of one uart channel
`timescale 1ns/1ns
`default_nettype none
module uart_fifo_control
#(
   parameter int INSTANCE = 0,
   parameter int DEPTH    = fifo_ctl_pkg::FIFO_DEPTH,
   parameter int WIDTH    = fifo_ctl_pkg::DATA_W
)
(
   input  wire logic                        clk_sys,
   input  wire logic                        rst,
   input  wire fifo_ctl_pkg::io_req_t       io_req,
   output logic [7:0]                       io_rdata,
   input  wire logic [3:0]                  iir_status,
   input  wire logic                        rx_interrupt_enable,
   input  wire logic                        rx_timeout,
   output logic                             rx_data_irq,
   output logic                             fifo_enabled,
   output logic                             rx_logic_reset,
   output logic                             tx_logic_reset,
   input  wire logic                        rx_in_valid,
   input  wire logic [WIDTH-1:0]            rx_in_data,
   output logic                             rx_in_ready,
   output logic                             rx_out_valid,
   output logic [WIDTH-1:0]                 rx_out_data,
   input  wire logic                        rx_out_ready,
   output logic [$clog2(DEPTH+1)-1:0]       rx_level,
   input  wire logic                        tx_in_valid,
   input  wire logic [WIDTH-1:0]            tx_in_data,
   output logic                             tx_in_ready,
   output logic                             tx_out_valid,
   output logic [WIDTH-1:0]                 tx_out_data,
   input  wire logic                        tx_out_ready
);
   localparam int LW = $clog2(DEPTH+1);
   localparam logic [15:0] MY_ADDR = (INSTANCE == 0)
      ? fifo_ctl_pkg::UART0_FIFO_CONTROL_ADDR
      : fifo_ctl_pkg::UART1_FIFO_CONTROL_ADDR;

   fifo_ctl_pkg::ctl_state_t st_r;
   fifo_ctl_pkg::ctl_state_t st_nxt;

   logic                          hit_wr;
   logic                          hit_rd;
   logic [fifo_ctl_pkg::LEVEL_W-1:0] trigger_lvl;
   logic [fifo_ctl_pkg::LEVEL_W-1:0] threshold;
   logic                          level_hit;
   logic [7:0]                    iir_val;
   logic [LW-1:0]                 rx_count;

   assign hit_wr = io_req.wr && io_req.addr == MY_ADDR;
   assign hit_rd = io_req.rd && io_req.addr == MY_ADDR;

   // same address: writes land in control, reads return status
   always_comb
   begin
      iir_val = 8'h00;
      iir_val[fifo_ctl_pkg::IIR_FIFO_BIT] = st_r.ctl.fifo_enable;
      iir_val[fifo_ctl_pkg::IIR_STATUS_W-1:0] = iir_status;
   end

   always_comb
   begin
      case (st_r.ctl.rx_trigger_level)
         fifo_ctl_pkg::TRIGGER_CODE_1:
            trigger_lvl = fifo_ctl_pkg::TRIGGER_LEVEL_1;
         fifo_ctl_pkg::TRIGGER_CODE_4:
            trigger_lvl = fifo_ctl_pkg::TRIGGER_LEVEL_4;
         fifo_ctl_pkg::TRIGGER_CODE_8:
            trigger_lvl = fifo_ctl_pkg::TRIGGER_LEVEL_8;
         fifo_ctl_pkg::TRIGGER_CODE_14:
            trigger_lvl = fifo_ctl_pkg::TRIGGER_LEVEL_14;
         default:
            trigger_lvl = fifo_ctl_pkg::TRIGGER_LEVEL_1;
      endcase
   end

   // single-byte mode: any held byte is data ready
   assign threshold = st_r.ctl.fifo_enable
                      ? trigger_lvl : fifo_ctl_pkg::TRIGGER_LEVEL_1;
   assign level_hit = rx_count >= LW'(threshold);

   always_comb
   begin
      st_nxt = st_r;
      if (hit_wr)
      begin
         st_nxt.ctl.rx_trigger_level =
            io_req.wdata[fifo_ctl_pkg::TRIGGER_LSB +: 2];
         st_nxt.ctl.tx_path_enable =
            io_req.wdata[fifo_ctl_pkg::TX_EN_BIT];
         st_nxt.ctl.rx_path_enable =
            io_req.wdata[fifo_ctl_pkg::RX_EN_BIT];
         st_nxt.ctl.fifo_enable =
            io_req.wdata[fifo_ctl_pkg::FIFO_EN_BIT];
      end
      if (hit_rd)
         st_nxt.rdata = iir_val;
      // timeout shares the same enable as the level interrupt
      st_nxt.rx_irq = rx_interrupt_enable
                      & (level_hit | rx_timeout);
      st_nxt.rx_hold = ~st_nxt.ctl.rx_path_enable;
      st_nxt.tx_hold = ~st_nxt.ctl.tx_path_enable;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         st_r <= fifo_ctl_pkg::CTL_STATE_RESET;
      else
         st_r <= st_nxt;
   end

   // path enables are persistent; only reset or a register write drops them
   byte_fifo
   #(
      .WIDTH (WIDTH),
      .DEPTH (DEPTH)
   )
   rx_fifo
   (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .clear     (~st_r.ctl.rx_path_enable),
      .single    (~st_r.ctl.fifo_enable),
      .in_valid  (rx_in_valid),
      .in_data   (rx_in_data),
      .in_ready  (rx_in_ready),
      .out_valid (rx_out_valid),
      .out_data  (rx_out_data),
      .out_ready (rx_out_ready),
      .level     (rx_count)
   );

   byte_fifo
   #(
      .WIDTH (WIDTH),
      .DEPTH (DEPTH)
   )
   tx_fifo
   (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .clear     (~st_r.ctl.tx_path_enable),
      .single    (~st_r.ctl.fifo_enable),
      .in_valid  (tx_in_valid),
      .in_data   (tx_in_data),
      .in_ready  (tx_in_ready),
      .out_valid (tx_out_valid),
      .out_data  (tx_out_data),
      .out_ready (tx_out_ready),
      .level     ()
   );

   assign io_rdata       = st_r.rdata;
   assign rx_data_irq    = st_r.rx_irq;
   assign fifo_enabled   = st_r.ctl.fifo_enable;
   assign rx_logic_reset = st_r.rx_hold;
   assign tx_logic_reset = st_r.tx_hold;
   assign rx_level       = rx_count;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   sequence wr_seq;
      hit_wr;
   endsequence

   sequence fifo_off_seq;
      !st_r.ctl.fifo_enable [*2];
   endsequence

   reg_write_a: assert property (
      wr_seq |=> st_r.ctl.fifo_enable ==
         $past(io_req.wdata[fifo_ctl_pkg::FIFO_EN_BIT])
      && st_r.ctl.rx_trigger_level ==
         $past(io_req.wdata[7:6])
      && st_r.ctl.tx_path_enable == $past(io_req.wdata[2])
      && st_r.ctl.rx_path_enable == $past(io_req.wdata[1]))
      else $error("control write not captured");

   iir_read_a: assert property (
      hit_rd |=> io_rdata == {$past(st_r.ctl.fifo_enable), 3'h0,
                             $past(iir_status)})
      else $error("read did not return status");

   ctl_hold_a: assert property (
      !hit_wr |=> st_r.ctl == $past(st_r.ctl))
      else $error("control changed without write");

   trigger_high_a: assert property (
      st_r.ctl.fifo_enable && rx_interrupt_enable
      && st_r.ctl.rx_trigger_level == 2'h3 && !rx_timeout
      |=> rx_data_irq == ($past(rx_count) >= LW'(14)))
      else $error("trigger 14 misjudged");

   trigger_off_a: assert property (
      !st_r.ctl.fifo_enable && rx_interrupt_enable
      && rx_count != '0 |=> rx_data_irq)
      else $error("trigger applied with fifos off");

   tx_held_a: assert property (
      !st_r.ctl.tx_path_enable |-> tx_logic_reset ##1 !tx_out_valid)
      else $error("transmit path not held");

   rx_held_a: assert property (
      !st_r.ctl.rx_path_enable |=> !rx_in_ready && rx_count == '0)
      else $error("receive path not held");

   single_buf_a: assert property (
      fifo_off_seq ##0 rx_count != '0 |-> !rx_in_ready)
      else $error("single buffer overfilled");

   irq_gate_a: assert property (
      !rx_interrupt_enable |=> !rx_data_irq)
      else $error("receive interrupt not gated");

   depth_room_a: assert property (
      st_r.ctl.fifo_enable && st_r.ctl.rx_path_enable
      && rx_count == LW'(14) ##1 st_r.ctl.fifo_enable
      |-> rx_in_ready)
      else $error("no room above top trigger");

endmodule // uart_fifo_control
`default_nettype wire

// >>> verification/far_end_model.sv
// far side model: serial byte source for receive, sink for transmit
`timescale 1ns/1ns
`default_nettype none
module far_end_model
(
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       send,
   input  wire logic       stall,
   output logic            rx_in_valid,
   output logic [7:0]      rx_in_data,
   input  wire logic       rx_in_ready,
   input  wire logic       tx_out_valid,
   input  wire logic [7:0] tx_out_data,
   output logic            tx_out_ready,
   output logic [7:0]      tx_got,
   output logic [7:0]      tx_count
);
   logic [7:0] next_r;
   // idle data shows the inverse so a stale byte never looks valid
   assign rx_in_data   = rx_in_valid ? next_r : ~next_r;
   assign tx_out_ready = ~stall;
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         rx_in_valid <= 1'b0;
         next_r      <= 8'h00;
         tx_got      <= 8'h00;
         tx_count    <= 8'h00;
      end
      else
      begin
         if (rx_in_valid && rx_in_ready)
            next_r <= next_r + 8'h01;
         // a byte on offer stays until taken
         rx_in_valid <= send || (rx_in_valid && !rx_in_ready);
         if (tx_out_valid && tx_out_ready)
         begin
            tx_got   <= tx_out_data;
            tx_count <= tx_count + 8'h01;
         end
      end
   end
endmodule // far_end_model
`default_nettype wire

// >>> verification/tb.sv
// testbench for one uart fifo control channel
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam logic [15:0] A = fifo_ctl_pkg::UART0_FIFO_CONTROL_ADDR;
   fifo_ctl_pkg::io_req_t io_req;
   logic       clk_sys, rst, rx_timeout, rx_out_ready, send, stall;
   logic       rx_interrupt_enable;
   logic       tx_in_valid, rx_data_irq, fifo_enabled, rx_in_valid;
   logic       rx_logic_reset, tx_logic_reset, rx_in_ready, rx_out_valid;
   logic       tx_in_ready, tx_out_valid, tx_out_ready;
   logic [3:0] iir_status;
   logic [4:0] rx_level;
   logic [7:0] tx_in_data, io_rdata, rx_in_data, rx_out_data, tx_out_data;
   logic [7:0] tx_got, tx_count;
   int         num_errors = 0;
   int         num_checks = 0;
   uart_fifo_control dut (.clk_sys, .rst, .io_req, .io_rdata, .iir_status,
      .rx_interrupt_enable, .rx_timeout, .rx_data_irq, .fifo_enabled,
      .rx_logic_reset, .tx_logic_reset, .rx_in_valid, .rx_in_data,
      .rx_in_ready, .rx_out_valid, .rx_out_data, .rx_out_ready, .rx_level,
      .tx_in_valid, .tx_in_data, .tx_in_ready, .tx_out_valid, .tx_out_data,
      .tx_out_ready);
   far_end_model far (.clk_sys, .rst, .send, .stall, .rx_in_valid,
      .rx_in_data, .rx_in_ready, .tx_out_valid, .tx_out_data, .tx_out_ready,
      .tx_got, .tx_count);
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task wr(input logic [7:0] d);
      @(posedge clk_sys);
      io_req <= '{1'b1, 1'b0, A, d};
      @(posedge clk_sys);
      io_req.wr <= 1'b0;
      #1;
   endtask
   task rd(input logic [15:0] a);
      @(posedge clk_sys);
      io_req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk_sys);
      io_req.rd <= 1'b0;
      #1;
   endtask
   task t_reg;
      chk("ctl", {fifo_enabled, rx_logic_reset, tx_logic_reset}, 8'h03);
      chk("ready", {rx_in_ready, tx_in_ready, rx_data_irq}, 8'h00);
      rd(A);
      chk("status", io_rdata, 8'h05);
      wr(8'h01);
      chk("fifo on", fifo_enabled, 8'h01);
      chk("tx held", tx_logic_reset, 8'h01);
      iir_status <= 4'h3;
      rd(A);
      chk("status", io_rdata, 8'h83);
      rd(16'h00c3);
      chk("other addr", io_rdata, 8'h83);
      wr(8'h07);
      cyc(1);
      chk("released", {rx_logic_reset, tx_logic_reset}, 8'h00);
      chk("ready", {rx_in_ready, tx_in_ready}, 8'h03);
      $display("test reg done");
   endtask
   task t_trigger(input logic [1:0] code, input logic [4:0] thr);
      logic [4:0] prev;
      wr(8'h01);
      wr({code, 6'h07});
      chk("cleared", rx_level, 8'h00);
      prev = rx_level;
      @(posedge clk_sys);
      send <= 1'b1;
      repeat (24)
      begin
         #1;
         chk("irq", rx_data_irq, prev >= thr);
         prev = rx_level;
         @(posedge clk_sys);
      end
      send <= 1'b0;
      #1;
      chk("full", {rx_level, rx_in_ready}, 8'h20);
      rx_interrupt_enable <= 1'b0;
      cyc(2);
      chk("irq masked", rx_data_irq, 8'h00);
      rx_interrupt_enable <= 1'b1;
      $display("test trigger %0d done", thr);
   endtask
   task t_drain;
      logic [7:0] e;
      int         n;
      n = 0;
      // last fill ran upward from 8'h30, then the held byte
      e = 8'h30;
      @(posedge clk_sys);
      rx_out_ready <= 1'b1;
      repeat (24)
      begin
         #1;
         if (rx_out_valid === 1'b1)
         begin
            chk("rx order", rx_out_data, e);
            e++;
            n++;
         end
         @(posedge clk_sys);
      end
      rx_out_ready <= 1'b0;
      #1;
      // sixteen stored plus the byte the far side held while full
      chk("popped", n[7:0], 8'h11);
      chk("empty", rx_level, 8'h00);
      rx_timeout <= 1'b1;
      cyc(2);
      chk("timeout irq", rx_data_irq, 8'h01);
      rx_interrupt_enable <= 1'b0;
      cyc(2);
      chk("timeout masked", rx_data_irq, 8'h00);
      rx_timeout          <= 1'b0;
      rx_interrupt_enable <= 1'b1;
      $display("test drain done");
   endtask
   task t_single;
      wr(8'h00);
      wr(8'hc6);
      @(posedge clk_sys);
      send <= 1'b1;
      cyc(6);
      chk("one byte", {rx_level, rx_in_ready}, 8'h02);
      chk("irq at one", rx_data_irq, 8'h01);
      send <= 1'b0;
      $display("test single done");
   endtask
   task t_tx;
      logic a;
      int   n;
      n = 0;
      wr(8'h07);
      @(posedge clk_sys);
      tx_in_valid <= 1'b1;
      repeat (24)
      begin
         #1;
         a = tx_in_ready;
         n += a;
         @(posedge clk_sys);
         if (a)
            tx_in_data <= tx_in_data + 8'h01;
      end
      tx_in_valid <= 1'b0;
      chk("tx fill", n[7:0], 8'h10);
      wr(8'h03);
      cyc(1);
      chk("tx off", {tx_logic_reset, tx_out_valid}, 8'h02);
      chk("rx kept", rx_logic_reset, 8'h00);
      wr(8'h07);
      stall <= 1'b0;
      cyc(2);
      tx_in_valid <= 1'b1;
      tx_in_data  <= 8'h5a;
      @(posedge clk_sys);
      tx_in_valid <= 1'b0;
      cyc(5);
      chk("tx byte", tx_got, 8'h5a);
      chk("tx count", tx_count, 8'h01);
      $display("test tx done");
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      // run is about 220 cycles; twenty thousand means a hang
      #400000;
      num_errors++;
      finish_test;
   end
   initial
   begin
      rst = 1'b1;
      io_req = '0;
      iir_status = 4'h5;
      rx_interrupt_enable = 1'b1;
      rx_timeout = 1'b0;
      rx_out_ready = 1'b0;
      tx_in_valid = 1'b0;
      tx_in_data = 8'h00;
      send = 1'b0;
      stall = 1'b1;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      #1;
      t_reg;
      t_trigger(fifo_ctl_pkg::TRIGGER_CODE_1,
                fifo_ctl_pkg::TRIGGER_LEVEL_1);
      t_trigger(fifo_ctl_pkg::TRIGGER_CODE_4,
                fifo_ctl_pkg::TRIGGER_LEVEL_4);
      t_trigger(fifo_ctl_pkg::TRIGGER_CODE_8,
                fifo_ctl_pkg::TRIGGER_LEVEL_8);
      t_trigger(fifo_ctl_pkg::TRIGGER_CODE_14,
                fifo_ctl_pkg::TRIGGER_LEVEL_14);
      t_drain;
      t_single;
      t_tx;
      finish_test;
   end
endmodule // tb
`default_nettype wire
